// [core/csw_defines.svh]
// shared constants for the cpu supervisor / watchdog / serial memory block
// assumes inclusion by csw_pkg and the design module
`ifndef CSW_DEFINES_SVH
`define CSW_DEFINES_SVH
`define CSW_CLK_MHZ 200
`define CSW_HOLD_MS 200
`define CSW_WRITE_MS 5
`define CSW_WD_00_MS 1400
`define CSW_WD_01_MS 600
`define CSW_WD_10_MS 200
`define CSW_CYC_PER_MS (`CSW_CLK_MHZ * 1000)
`define CSW_OP_LATCH_WRITE_ENABLE_CMD 8'h06
`define CSW_OP_WRDI 8'h04
`define CSW_OP_RDSR 8'h05
`define CSW_OP_WRSR 8'h01
`define CSW_OP_READ 3'h3
`define CSW_OP_WRITE 3'h2
`define CSW_SET_ADDR 9'h001
`define CSW_RST_ADDR 9'h003
`define CSW_SET_DATA 8'h00
`define CSW_SR_DEFAULT 4'hc
`define CSW_WD_OFF 2'h3
`define CSW_PAGE_BYTES 16
`endif

// [core/csw_pkg.sv]
// types for the cpu supervisor block
// assumes csw_defines.svh on the include path
`include "csw_defines.svh"
package csw_pkg;
  typedef enum logic [2:0] {
    CSW_OPC = 3'b000,
    CSW_ADR = 3'b001,
    CSW_DAT = 3'b010,
    CSW_RDO = 3'b011,
    CSW_SRW = 3'b100,
    CSW_IGN = 3'b101
  } csw_phase_e;
endpackage

// [core/csw_supervisor.sv]
// cpu supervisor: power-on/brown-out reset hold, watchdog, serial memory with
// write guard, region lock and trip-threshold programming sequence
// assumes analogue comparators deliver supply_low_i and prog_volt_i as levels
`timescale 1ns/1ps
`include "csw_defines.svh"
module csw_supervisor import csw_pkg::*; #(
  parameter int HOLD_CYC = `CSW_HOLD_MS * `CSW_CYC_PER_MS,
  parameter int WRITE_CYC = `CSW_WRITE_MS * `CSW_CYC_PER_MS,
  parameter int WD0_CYC = `CSW_WD_00_MS * `CSW_CYC_PER_MS,
  parameter int WD1_CYC = `CSW_WD_01_MS * `CSW_CYC_PER_MS,
  parameter int WD2_CYC = `CSW_WD_10_MS * `CSW_CYC_PER_MS,
  parameter bit RESET_HIGH = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic write_guard_n_i,
  input wire logic supply_low_i,
  input wire logic prog_volt_i,
  output logic so_o,
  output logic so_oe_o,
  output logic reset_out_o,
  output logic reset_oe_o,
  output logic standby_o,
  output logic busy_o,
  output logic trip_set_o,
  output logic trip_clear_o
);
  localparam int CW = 32;
  if (HOLD_CYC < 1 || WRITE_CYC < 1 || WD0_CYC < 1 || WD1_CYC < 1 || WD2_CYC < 1) begin
    $error("csw_supervisor: counts must be at least one");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_s1, cs_s2;
  logic [4:0] meta, sync;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // idle pin levels: select high, clock low, guard high, supply_low high
      meta <= 5'h13;
      sync <= 5'h13;
    end else begin
      meta <= {cs_n_i, sck_i, si_i, write_guard_n_i, supply_low_i};
      sync <= meta;
    end
  end
  wire cs_n = sync[4];
  wire sck = sync[3];
  wire si = sync[2];
  wire guard_n = sync[1];
  wire supply_low = sync[0];
  logic prog_m, prog_s, cs_d, sck_d, guard_d;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_m <= 1'b0;
      prog_s <= 1'b0;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
      guard_d <= 1'b1;
    end else begin
      prog_m <= prog_volt_i;
      prog_s <= prog_m;
      cs_d <= cs_n;
      sck_d <= sck;
      guard_d <= guard_n;
    end
  end
  wire cs_fall = cs_d & ~cs_n;
  wire cs_rise = ~cs_d & cs_n;
  wire sck_rise = ~sck_d & sck & ~cs_n;
  wire sck_fall = sck_d & ~sck & ~cs_n;
  wire guard_fall = guard_d & ~guard_n;

  // ----------------------------------------------------------------
  // memory, status and serial protocol
  // ----------------------------------------------------------------
  logic [7:0] mem [0:511];
  logic [1:0] wd_sel, lock_sel;
  logic wel, armed, mode_ok, wip, pend, pend_sr, abort;
  logic [7:0] shreg, opcode, outreg;
  logic [2:0] bitcnt;
  logic [8:0] addr, base;
  logic [4:0] nbytes;
  logic [7:0] page [0:15];
  logic [1:0] new_wd, new_lock;
  logic [CW-1:0] wr_cnt;
  csw_phase_e phase;
  wire [7:0] next_shreg = {shreg[6:0], si};
  wire byte_done = sck_rise && bitcnt == 3'h7;
  wire [7:0] status = {2'h0, wd_sel, lock_sel, wel, wip};

  function automatic logic locked(input logic [1:0] sel, input logic [8:0] a);
    case (sel)
      2'h1: locked = a[8] & a[7];
      2'h2: locked = a[8];
      2'h3: locked = 1'b1;
      default: locked = 1'b0;
    endcase
  endfunction

  wire op_write = opcode[2:0] == `CSW_OP_WRITE && opcode[7:4] == 4'h0;
  wire wr_ok = wel & guard_n & ~abort & ~wip;
  wire first_lock = locked(lock_sel, base);
  wire special = base == `CSW_SET_ADDR || base == `CSW_RST_ADDR;
  wire fire_arr = cs_rise && phase == CSW_DAT && op_write && pend && wr_ok &&
    nbytes != 5'h0 && bitcnt == 3'h0;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {wd_sel, lock_sel} <= `CSW_SR_DEFAULT;
      wel <= 1'b0;
      armed <= 1'b0;
      mode_ok <= 1'b0;
      phase <= CSW_OPC;
      shreg <= 8'h00;
      opcode <= 8'h00;
      outreg <= 8'h00;
      bitcnt <= 3'h0;
      addr <= 9'h000;
      base <= 9'h000;
      nbytes <= 5'h00;
      pend <= 1'b0;
      pend_sr <= 1'b0;
      abort <= 1'b0;
      new_wd <= 2'h0;
      new_lock <= 2'h0;
      wip <= 1'b0;
      wr_cnt <= '0;
      trip_set_o <= 1'b0;
      trip_clear_o <= 1'b0;
    end else begin
      if (cs_fall) begin
        armed <= 1'b1;
        mode_ok <= sck_d == sck;
        phase <= CSW_OPC;
        bitcnt <= 3'h0;
        pend <= 1'b0;
        pend_sr <= 1'b0;
        abort <= 1'b0;
        nbytes <= 5'h00;
      end
      if (guard_fall) begin
        wel <= 1'b0;
        if (!cs_n) abort <= 1'b1;
      end
      if (armed && mode_ok && sck_rise && phase != CSW_IGN) begin
        shreg <= next_shreg;
        bitcnt <= bitcnt + 3'h1;
        if (byte_done) begin
          case (phase)
            CSW_OPC: begin
              opcode <= next_shreg;
              phase <= CSW_IGN;
              if (next_shreg == `CSW_OP_LATCH_WRITE_ENABLE_CMD && !wip) wel <= 1'b1;
              else if (next_shreg == `CSW_OP_WRDI && !wip) wel <= 1'b0;
              else if (next_shreg == `CSW_OP_RDSR) begin
                phase <= CSW_RDO;
                outreg <= status;
              end else if (next_shreg == `CSW_OP_WRSR) phase <= CSW_SRW;
              else if (next_shreg[7:4] == 4'h0 && (next_shreg[2:0] == `CSW_OP_READ ||
                       next_shreg[2:0] == `CSW_OP_WRITE)) phase <= CSW_ADR;
            end
            CSW_ADR: begin
              addr <= {opcode[3], next_shreg};
              base <= {opcode[3], next_shreg};
              // read data is fetched by the falling edge that opens each byte
              if (op_write) phase <= CSW_DAT;
              else phase <= CSW_RDO;
            end
            CSW_DAT: begin
              if (nbytes != 5'(`CSW_PAGE_BYTES)) begin
                page[addr[3:0]] <= next_shreg;
                nbytes <= nbytes + 5'h01;
              end
              addr <= {addr[8:4], addr[3:0] + 4'h1};
              pend <= 1'b1;
            end
            CSW_SRW: begin
              new_wd <= next_shreg[5:4];
              new_lock <= next_shreg[3:2];
              pend_sr <= 1'b1;
              phase <= CSW_IGN;
            end
            default: ;
          endcase
        end
      end
      if (armed && mode_ok && sck_fall && phase == CSW_RDO) begin
        if (bitcnt == 3'h0) begin
          outreg <= opcode == `CSW_OP_RDSR ? status : mem[addr];
          addr <= addr + 9'h001;
        end else outreg <= {outreg[6:0], 1'b0};
      end
      // self-timed write cycle starts on select rising
      if (cs_rise && ((fire_arr && !first_lock) || (pend_sr && wr_ok && bitcnt == 3'h0))) begin
        wip <= 1'b1;
        wr_cnt <= '0;
        wel <= 1'b0;
        trip_set_o <= fire_arr && prog_s && base == `CSW_SET_ADDR && nbytes == 5'h01 &&
          page[base[3:0]] == `CSW_SET_DATA && special;
        trip_clear_o <= fire_arr && prog_s && base == `CSW_RST_ADDR && nbytes == 5'h01 &&
          page[base[3:0]] == `CSW_SET_DATA;
      end else if (wip) begin
        if (trip_set_o || trip_clear_o) begin
          if (!guard_n) begin
            trip_set_o <= 1'b0;
            trip_clear_o <= 1'b0;
          end
        end
        if (wr_cnt == CW'(WRITE_CYC - 1)) begin
          wip <= 1'b0;
          pend <= 1'b0;
          if (pend_sr) begin
            wd_sel <= new_wd;
            lock_sel <= new_lock;
            pend_sr <= 1'b0;
          end
        end else wr_cnt <= wr_cnt + CW'(1);
      end
    end
  end

  // array update at the end of the timed cycle, lock checked per byte
  wire wr_done = wip && wr_cnt == CW'(WRITE_CYC - 1) && pend;
  always_ff @(posedge mclk_i) begin
    if (wr_done) begin
      for (int i = 0; i < `CSW_PAGE_BYTES; i++) begin
        if (5'(i) < nbytes && !locked(lock_sel, {base[8:4], 4'(base[3:0] + 4'(i))}))
          mem[{base[8:4], 4'(base[3:0] + 4'(i))}] <= page[4'(base[3:0] + 4'(i))];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs of the serial side
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_o <= outreg[7];
      so_oe_o <= ~cs_n && armed && phase == CSW_RDO;
    end
  end
  assign standby_o = cs_n & ~wip;
  assign busy_o = wip;

  // ----------------------------------------------------------------
  // supply hold and watchdog
  // ----------------------------------------------------------------
  logic [CW-1:0] hold_cnt, wd_cnt;
  logic hold_rst, wd_rst;
  wire [CW-1:0] wd_lim = wd_sel == 2'h0 ? CW'(WD0_CYC) :
                         wd_sel == 2'h1 ? CW'(WD1_CYC) : CW'(WD2_CYC);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_cnt <= '0;
      hold_rst <= 1'b1;
      wd_cnt <= '0;
      wd_rst <= 1'b0;
    end else begin
      if (supply_low) begin
        hold_cnt <= '0;
        hold_rst <= 1'b1;
      end else if (hold_rst) begin
        if (hold_cnt == CW'(HOLD_CYC - 1)) hold_rst <= 1'b0;
        else hold_cnt <= hold_cnt + CW'(1);
      end
      if (cs_fall || wd_sel == `CSW_WD_OFF || hold_rst) begin
        wd_cnt <= '0;
        wd_rst <= 1'b0;
      end else if (wd_cnt >= wd_lim - CW'(1)) wd_rst <= 1'b1;
      else wd_cnt <= wd_cnt + CW'(1);
    end
  end
  // open drain: pull to active level, else release
  assign reset_out_o = RESET_HIGH;
  assign reset_oe_o = hold_rst | wd_rst;
endmodule

// [test/csw_spi_master.sv]
// serial bus master standing in for the microcontroller
// assumes the bench calls xfer off the falling mclk edge
`timescale 1ns/1ps
module csw_spi_master (
  input wire logic mclk_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  logic cpol = 1'b0;
  logic tog = 1'b0;
  logic si_q = 1'b0;
  initial cs_n_o = 1'b1;
  initial sck_o = 1'b0;
  // released data line toggles so a stale bit is never seen
  assign si_o = cs_n_o ? tog : si_q;
  always @(negedge mclk_i) begin
    tog <= ~tog;
  end
  task automatic xfer(input int nbytes, input logic [151:0] tx, output logic [151:0] rx);
    rx = '0;
    sck_o = cpol;
    repeat (13) @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (13) @(negedge mclk_i);
    for (int i = 0; i < 8 * nbytes; i++) begin
      sck_o = 1'b0;
      si_q = tx[151 - i];
      repeat (12) @(negedge mclk_i);
      rx[151 - i] = so_oe_i ? so_i : 1'bz;
      sck_o = 1'b1;
      repeat (13) @(negedge mclk_i);
    end
    sck_o = cpol;
    repeat (13) @(negedge mclk_i);
    cs_n_o = 1'b1;
    repeat (13) @(negedge mclk_i);
  endtask
endmodule

// [test/csw_supervisor_asserts.sv]
// port assertions for the supervisor
// assumes a bind onto csw_supervisor from the bench top
`timescale 1ns/1ps
module csw_supervisor_asserts #(
  parameter int HOLD_CYC = 200,
  parameter int WRITE_CYC = 50,
  parameter bit RESET_HIGH = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic write_guard_n_i,
  input wire logic supply_low_i,
  input wire logic prog_volt_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic reset_out_o,
  input wire logic reset_oe_o,
  input wire logic standby_o,
  input wire logic busy_o,
  input wire logic trip_set_o
);
  localparam int HOLD_LO = HOLD_CYC - 2;
  localparam int WR_LO = WRITE_CYC - 3;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_hold;
    reset_oe_o throughout ##[HOLD_LO:HOLD_LO] 1;
  endsequence
  sequence s_write;
    busy_o throughout ##[WR_LO:WR_LO] 1;
  endsequence
  AST_DESEL_FLOAT: assert property (cs_n_i [*4] |-> !so_oe_o)
    else $error("serial output driven while deselected");
  AST_AWAKE: assert property ((!cs_n_i) [*4] |-> !standby_o)
    else $error("standby while selected");
  AST_BUSY_AWAKE: assert property (cs_n_i [*4] |-> (standby_o == !busy_o))
    else $error("standby during write cycle");
  AST_LOW_SUPPLY: assert property (supply_low_i [*4] |-> reset_oe_o)
    else $error("reset not active on low supply");
  AST_HOLD: assert property ($fell(supply_low_i) |-> s_hold ##[1:12] !reset_oe_o)
    else $error("reset hold length wrong");
  AST_RST_LEVEL: assert property (reset_out_o == RESET_HIGH)
    else $error("reset level wrong");
  AST_BUSY_LEN: assert property ($rose(busy_o) && !prog_volt_i |-> s_write ##[1:8] !busy_o)
    else $error("write cycle length wrong");
  AST_SO_EDGE: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !$past(sck_i, 4))
    else $error("serial output changed outside clock low");
  AST_TRIP_START: assert property ($rose(trip_set_o) |-> prog_volt_i && cs_n_i)
    else $error("threshold programming started wrongly");
  AST_TRIP_END: assert property (trip_set_o && $fell(write_guard_n_i) |-> ##[1:6] !trip_set_o)
    else $error("threshold programming not ended");
endmodule

// [test/test_csw_supervisor.sv]
// self-checking bench for the supervisor with a serial master model
// assumes csw_pkg, the design and the other test files compiled first
`timescale 1ns/1ps
module test_csw_supervisor;
  localparam int HOLD = 200;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic guard_n = 1'b1;
  logic sup_low = 1'b0;
  logic prog = 1'b0;
  logic cs_n, sck, si, so, so_oe, rst_out, rst_oe, standby, busy, tset, tclr;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  logic [151:0] rx;
  always #2.5 mclk = ~mclk;
  csw_spi_master u_mst (.mclk_i(mclk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));
  csw_supervisor #(.HOLD_CYC(HOLD), .WRITE_CYC(50), .WD0_CYC(1600), .WD1_CYC(1200),
    .WD2_CYC(800), .RESET_HIGH(1'b0)) u_dut (.mclk_i(mclk), .rstn_i(rst_n), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .write_guard_n_i(guard_n), .supply_low_i(sup_low),
    .prog_volt_i(prog), .so_o(so), .so_oe_o(so_oe), .reset_out_o(rst_out),
    .reset_oe_o(rst_oe), .standby_o(standby), .busy_o(busy), .trip_set_o(tset),
    .trip_clear_o(tclr));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic op(input int n, input logic [31:0] b);
    u_mst.xfer(n, {b, 120'h0}, rx);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge mclk);
  endtask
  task automatic hold_chk;
    wait_n(HOLD - 10);
    chk(8'(rst_oe), 8'h1);
    wait_n(30);
    chk(8'(rst_oe), 8'h0);
  endtask
  function automatic logic [7:0] rb(input int i);
    return rx[151 - 8 * i -: 8];
  endfunction
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    logic [7:0] e;
    e = 8'h0;
    wait_n(3);
    rst_n = 1'b1;
    wait_n(3);
    chk(8'(standby), 8'h1);
    chk(8'(rst_out), 8'h0);
    hold_chk;
    op(1, 32'h06000000);
    op(4, 32'h0210a55a);
    op(4, 32'h0210ffff);
    u_mst.cpol = 1'b1;
    op(4, 32'h03100000);
    chk(rb(2), 8'ha5);
    chk(rb(3), 8'h5a);
    u_mst.cpol = 1'b0;
    guard_n = 1'b0;
    op(1, 32'h06000000);
    op(4, 32'h0210ffff);
    op(4, 32'h03100000);
    chk(rb(2), 8'ha5);
    guard_n = 1'b1;
    for (int b = 0; b < 4; b++) begin
      op(1, 32'h06000000);
      op(2, {8'h01, 4'h3, 2'(b), 2'b00, 16'h0});
      op(2, 32'h05000000);
      chk(rb(1), {4'h3, 2'(b), 2'b00});
      op(1, 32'h06000000);
      op(3, {8'h0a, 8'h40, 8'(b), 8'h0});
      if (b < 2) e = 8'(b);
      op(3, 32'h0b400000);
      chk(rb(2), e);
    end
    // unlock the array so the threshold writes can land
    op(1, 32'h06000000);
    op(2, 32'h01300000);
    prog = 1'b1;
    for (int k = 0; k < 2; k++) begin
      op(1, 32'h06000000);
      u_mst.xfer(3, {8'h02, 8'(3 - 2 * k), 8'h00, 128'h0}, rx);
      chk(8'(busy), 8'h1);
      chk(8'({tclr, tset}), 8'(2 >> k));
      guard_n = 1'b0;
      wait_n(8);
      chk(8'({tclr, tset}), 8'h0);
      guard_n = 1'b1;
      wait_n(60);
      op(3, {8'h03, 8'(3 - 2 * k), 16'h0});
      chk(rb(2), 8'h00);
    end
    prog = 1'b0;
    sup_low = 1'b1;
    wait_n(20);
    chk(8'(rst_oe), 8'h1);
    sup_low = 1'b0;
    hold_chk;
    for (int w = 0; w < 3; w++) begin
      op(1, 32'h06000000);
      op(2, {8'h01, 2'b00, 2'(2 - w), 4'h0, 16'h0});
      op(1, 32'h06000000);
      wait_n(400 * w + 400);
      chk(8'(rst_oe), 8'h0);
      wait_n(300);
      chk(8'(rst_oe), 8'h1);
    end
    op(1, 32'h06000000);
    op(2, 32'h01300000);
    wait_n(2000);
    chk(8'(rst_oe), 8'h0);
    print_verdict;
  end
endmodule
bind csw_supervisor csw_supervisor_asserts #(.HOLD_CYC(HOLD_CYC), .WRITE_CYC(WRITE_CYC),
  .RESET_HIGH(RESET_HIGH)) u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .sck_i(sck_i), .write_guard_n_i(write_guard_n_i), .supply_low_i(supply_low_i),
  .prog_volt_i(prog_volt_i), .so_o(so_o), .so_oe_o(so_oe_o), .reset_out_o(reset_out_o),
  .reset_oe_o(reset_oe_o), .standby_o(standby_o), .busy_o(busy_o), .trip_set_o(trip_set_o));
